// *** pdic_top.sv ***
`timescale 1ns/1ps
// What this block does
// - Direction bits 0, 1 steer C low, B
// - Direction bit 3 steers C high nibble
// - Direction bit 4 steers whole port A
// - Reset makes all ports inputs
// - Direction bits 2, 5, 6, 7 ignored
// - Enabled group interrupts from port A bit 0
// - Interrupt enable gates; resets to zero
// - Mode: low, high, falling, rising
// - Reading offset 5 clears pending flags
// - Pending in D0 and D4, rest zero
// - Setup registers at 4 and C, readable
// - Output registers keep writes either direction
// - Output ports read back driven value
module pdic_top
    import pdic_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [3:0] ADDR_I,
    input wire logic RD_I,
    input wire logic WR_I,
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O,
    input wire logic [23:0] PIN1_I,
    output logic [23:0] PIN1_O,
    output logic [23:0] PIN1_OE_N_O,
    input wire logic [23:0] PIN2_I,
    output logic [23:0] PIN2_O,
    output logic [23:0] PIN2_OE_N_O,
    output logic IRQ_O
);
    logic [7:0] rdata1;
    logic [7:0] rdata2;
    pdic_irq_s setup1;
    pdic_irq_s setup2;
    logic trig1;
    logic trig2;
    logic group1_pending_reg;
    logic group2_pending_reg;
    logic status_rd;
    logic grp2;
    logic [1:0] sel;

    // Port data offsets are 0 to 2 within either group
    function automatic logic is_port_ofs(input logic [3:0] a);
        return a[2:0] <= OFS_PORT_C1[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; bit 3 picks the group
    assign grp2 = ADDR_I[3];
    assign sel = (ADDR_I[2:0] == OFS_IRQ_SETUP1[2:0]) ? 2'h3 : ADDR_I[1:0];
    assign status_rd = RD_I && ADDR_I == OFS_IRQ_PENDING;

    pdic_group u_group1 (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .wr_dir_i(WR_I && ADDR_I == OFS_DIR1),
        .wr_irq_i(WR_I && ADDR_I == OFS_IRQ_SETUP1),
        .port_sel_i(sel),
        .wr_port_i(WR_I && !grp2 && is_port_ofs(ADDR_I)),
        .wdata_i(WDATA_I),
        .pin_i(PIN1_I),
        .pin_o(PIN1_O),
        .pin_oe_n_o(PIN1_OE_N_O),
        .rdata_o(rdata1),
        .irq_setup_o(setup1),
        .trigger_o(trig1)
    );

    pdic_group u_group2 (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .wr_dir_i(WR_I && ADDR_I == OFS_DIR2),
        .wr_irq_i(WR_I && ADDR_I == OFS_IRQ_SETUP2),
        .port_sel_i(sel),
        .wr_port_i(WR_I && grp2 && is_port_ofs(ADDR_I)),
        .wdata_i(WDATA_I),
        .pin_i(PIN2_I),
        .pin_o(PIN2_O),
        .pin_oe_n_o(PIN2_OE_N_O),
        .rdata_o(rdata2),
        .irq_setup_o(setup2),
        .trigger_o(trig2)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pending flags: a trigger in the clearing read's cycle wins, so none is lost
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            group1_pending_reg <= 1'b0;
            group2_pending_reg <= 1'b0;
        end else begin
            group1_pending_reg <= (setup1.irq_enable_bit && trig1)
                                || (group1_pending_reg && !status_rd);
            group2_pending_reg <= (setup2.irq_enable_bit && trig2)
                                || (group2_pending_reg && !status_rd);
        end
    end

    // Request follows the pending flags, registered for a clean output
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= group1_pending_reg || group2_pending_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data registered one cycle after RD_I; direction words read zero
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                OFS_IRQ_PENDING: RDATA_O <= {3'h0, group2_pending_reg, 3'h0,
                                             group1_pending_reg};
                OFS_PORT_A1, OFS_PORT_B1, OFS_PORT_C1, OFS_IRQ_SETUP1: RDATA_O <= rdata1;
                OFS_PORT_A2, OFS_PORT_B2, OFS_PORT_C2, OFS_IRQ_SETUP2: RDATA_O <= rdata2;
                default: RDATA_O <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_CLEAR_ON_READ: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        status_rd && !(setup1.irq_enable_bit && trig1) |=> !group1_pending_reg)
        else $error("status read did not clear group 1");
    AST_STATUS_LAYOUT: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        status_rd |=> RDATA_O == {3'h0, $past(group2_pending_reg), 3'h0,
                                  $past(group1_pending_reg)})
        else $error("status layout wrong");
    AST_ENABLE_GATES: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !group2_pending_reg && !setup2.irq_enable_bit |=> !group2_pending_reg)
        else $error("disabled group went pending");
    AST_PENDING_SET: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        setup1.irq_enable_bit && trig1 |=> group1_pending_reg ##1 IRQ_O)
        else $error("trigger did not raise request");
    AST_SETUP_READ: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        RD_I && ADDR_I == OFS_IRQ_SETUP2 |=> RDATA_O == {5'h00, $past(setup2)})
        else $error("setup readback wrong");
    AST_REQ_IDLE: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !group1_pending_reg && !group2_pending_reg |=> !IRQ_O)
        else $error("request without pending");
    // Group 2 mirrors the group 1 clear and set checks, group 1 the gate check
    AST_CLEAR_ON_READ2: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        status_rd && !(setup2.irq_enable_bit && trig2) |=> !group2_pending_reg)
        else $error("status read did not clear group 2");
    AST_ENABLE_GATES1: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !group1_pending_reg && !setup1.irq_enable_bit |=> !group1_pending_reg)
        else $error("disabled group 1 went pending");
    AST_PENDING_SET2: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        setup2.irq_enable_bit && trig2 |=> group2_pending_reg ##1 IRQ_O)
        else $error("group 2 trigger did not raise request");
    // A pending flag only leaves through a status read
    AST_PENDING_HOLD1: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        group1_pending_reg && !status_rd |=> group1_pending_reg)
        else $error("group 1 pending lost without a read");
    AST_PENDING_HOLD2: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        group2_pending_reg && !status_rd |=> group2_pending_reg)
        else $error("group 2 pending lost without a read");
    AST_REQ_SET: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        group1_pending_reg || group2_pending_reg |=> IRQ_O)
        else $error("pending without request");
    // Read side: setup readback, write-only words, unused status bits, data hold
    AST_SETUP_READ1: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        RD_I && ADDR_I == OFS_IRQ_SETUP1 |=> RDATA_O == {5'h00, $past(setup1)})
        else $error("group 1 setup readback wrong");
    AST_DIR_READ_ZERO: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        RD_I && (ADDR_I == OFS_DIR1 || ADDR_I == OFS_DIR2) |=> RDATA_O == 8'h00)
        else $error("direction word read back non-zero");
    AST_STATUS_ZERO: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        status_rd |=> (RDATA_O & 8'hee) == 8'h00)
        else $error("unused status bits set");
    AST_RDATA_HOLD: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !RD_I |=> $stable(RDATA_O))
        else $error("read data changed without a read");
    COV_STATUS_READ: cover property (@(posedge CLOCK_I) group1_pending_reg && status_rd);
    COV_BOTH_PENDING: cover property (@(posedge CLOCK_I) group1_pending_reg && group2_pending_reg);
    COV_DIR_WRITE: cover property (@(posedge CLOCK_I) WR_I && ADDR_I == OFS_DIR2);
    COV_EDGE_LATCH: cover property (@(posedge CLOCK_I) setup1.mode == MODE_RISE_EDGE && trig1);
    COV_LEVEL_REARM: cover property (@(posedge CLOCK_I) status_rd && setup2.irq_enable_bit && trig2);
endmodule

// *** pdic_pkg.sv ***
package pdic_pkg;
    // Register offsets within the 16-byte window
    localparam logic [3:0] OFS_PORT_A1 = 4'h0;
    localparam logic [3:0] OFS_PORT_B1 = 4'h1;
    localparam logic [3:0] OFS_PORT_C1 = 4'h2;
    localparam logic [3:0] OFS_DIR1 = 4'h3;
    localparam logic [3:0] OFS_IRQ_SETUP1 = 4'h4;
    localparam logic [3:0] OFS_IRQ_PENDING = 4'h5;
    localparam logic [3:0] OFS_PORT_A2 = 4'h8;
    localparam logic [3:0] OFS_PORT_B2 = 4'h9;
    localparam logic [3:0] OFS_PORT_C2 = 4'ha;
    localparam logic [3:0] OFS_DIR2 = 4'hb;
    localparam logic [3:0] OFS_IRQ_SETUP2 = 4'hc;
    // Direction word bit positions
    localparam int DIR_C_LOW_POS = 0;
    localparam int DIR_B_POS = 1;
    localparam int DIR_C_HIGH_POS = 3;
    localparam int DIR_A_POS = 4;
    // Interrupt setup and pending bit positions
    localparam int IRQ_ENABLE_POS = 2;
    localparam int GROUP1_PENDING_POS = 0;
    localparam int GROUP2_PENDING_POS = 4;
    // Values after reset
    localparam logic [3:0] DIR_RESET = 4'hf;
    localparam logic [2:0] IRQ_SETUP_RESET = 3'h0;
    localparam logic [7:0] OUT_RESET = 8'h00;
    // Interrupt trigger modes
    typedef enum logic [1:0] {
        MODE_LOW_LEVEL = 2'b00,
        MODE_HIGH_LEVEL = 2'b01,
        MODE_FALL_EDGE = 2'b10,
        MODE_RISE_EDGE = 2'b11
    } pdic_mode_e;
    // Direction bits, one means input
    typedef struct packed {
        logic dir_a_bit;
        logic dir_c_high_bit;
        logic dir_b_bit;
        logic dir_c_low_bit;
    } pdic_dir_s;
    // Interrupt setup of one group
    typedef struct packed {
        logic irq_enable_bit;
        pdic_mode_e mode;
    } pdic_irq_s;
endpackage

// *** pdic_group.sv ***
`timescale 1ns/1ps
// One 24-bit group: output registers, direction, pin enables, trigger detect
module pdic_group
    import pdic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_dir_i,
    input wire logic wr_irq_i,
    input wire logic [1:0] port_sel_i,
    input wire logic wr_port_i,
    input wire logic [7:0] wdata_i,
    input wire logic [23:0] pin_i,
    output logic [23:0] pin_o,
    output logic [23:0] pin_oe_n_o,
    output logic [7:0] rdata_o,
    output pdic_irq_s irq_setup_o,
    output logic trigger_o
);
    logic [7:0] out_a_reg;
    logic [7:0] out_b_reg;
    logic [7:0] out_c_reg;
    pdic_dir_s dir_reg;
    pdic_irq_s irq_reg;
    logic [23:0] sync1_reg;
    logic [23:0] sync2_reg;
    logic [23:0] sync3_reg;
    logic [23:0] pin_level_reg;
    logic bit0_prev_reg;
    logic [23:0] in_mask;

    // Expand direction bits to a per-pin input mask
    assign in_mask = {{4{dir_reg.dir_c_high_bit}}, {4{dir_reg.dir_c_low_bit}},
                      {8{dir_reg.dir_b_bit}}, {8{dir_reg.dir_a_bit}}};
    assign irq_setup_o = irq_reg;

    // Output registers keep writes in either direction
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_a_reg <= OUT_RESET;
            out_b_reg <= OUT_RESET;
            out_c_reg <= OUT_RESET;
        end else if (wr_port_i) begin
            case (port_sel_i)
                2'h0: out_a_reg <= wdata_i;
                2'h1: out_b_reg <= wdata_i;
                2'h2: out_c_reg <= wdata_i;
                default: out_a_reg <= out_a_reg;
            endcase
        end
    end

    // Direction word; unused bits 2, 5, 6, 7 are dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_reg <= DIR_RESET;
        end else if (wr_dir_i) begin
            dir_reg.dir_c_low_bit <= wdata_i[DIR_C_LOW_POS];
            dir_reg.dir_b_bit <= wdata_i[DIR_B_POS];
            dir_reg.dir_c_high_bit <= wdata_i[DIR_C_HIGH_POS];
            dir_reg.dir_a_bit <= wdata_i[DIR_A_POS];
        end
    end

    // Interrupt setup register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_reg <= IRQ_SETUP_RESET;
        end else if (wr_irq_i) begin
            irq_reg <= pdic_irq_s'(wdata_i[IRQ_ENABLE_POS:0]);
        end
    end

    // Pins pass three flops; a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
            pin_level_reg <= '1;
            bit0_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_level_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg))
                           | (pin_level_reg & (sync2_reg ^ sync3_reg));
            bit0_prev_reg <= pin_level_reg[0];
        end
    end

    // Drive pins from registered outputs, enable low while driving
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o <= '0;
            pin_oe_n_o <= '1;
        end else begin
            pin_o <= {out_c_reg, out_b_reg, out_a_reg};
            pin_oe_n_o <= in_mask;
        end
    end

    // Read mux: outputs read back the driven value, inputs the pin
    always_comb begin
        logic [23:0] view;
        view = (pin_level_reg & in_mask) | ({out_c_reg, out_b_reg, out_a_reg} & ~in_mask);
        case (port_sel_i)
            2'h0: rdata_o = view[7:0];
            2'h1: rdata_o = view[15:8];
            2'h2: rdata_o = view[23:16];
            default: rdata_o = {5'h00, irq_reg};
        endcase
    end

    // Trigger from port A bit zero in the selected mode
    always_comb begin
        case (irq_reg.mode)
            MODE_LOW_LEVEL: trigger_o = ~pin_level_reg[0];
            MODE_HIGH_LEVEL: trigger_o = pin_level_reg[0];
            MODE_FALL_EDGE: trigger_o = bit0_prev_reg & ~pin_level_reg[0];
            MODE_RISE_EDGE: trigger_o = ~bit0_prev_reg & pin_level_reg[0];
            default: trigger_o = 1'b0;
        endcase
    end

    AST_DIR_RESET: assert property (@(posedge clk_i) $rose(rst_n_i) |-> dir_reg == DIR_RESET)
        else $error("direction not all inputs after reset");
    AST_DIR_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_dir_i |=> dir_reg.dir_a_bit == $past(wdata_i[DIR_A_POS])
            && dir_reg.dir_c_high_bit == $past(wdata_i[DIR_C_HIGH_POS]))
        else $error("direction word not loaded");
    AST_OE_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_dir_i ##1 !wr_dir_i |=> pin_oe_n_o[7:0] == {8{dir_reg.dir_a_bit}})
        else $error("port A enable disagrees with direction");
    AST_OUT_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_port_i && port_sel_i == 2'h0 && !wr_dir_i ##1 !wr_dir_i
            |=> pin_o[7:0] == $past(wdata_i, 2))
        else $error("preset value not driven");
endmodule

// *** pdic_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the byte register bus, one access at a time
module pdic_host_model
    import pdic_pkg::*;
(
    input wire logic clk_i,
    output logic [3:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] wdata_o
);
    // Expected read data, oldest first, taken by the bench monitor
    logic [7:0] exp_q[$];

    // Idle bus at time zero
    initial begin
        addr_o = 4'h0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end

    // One-cycle write strobe; released lines show the inverse so stale data never passes
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // One-cycle read strobe; the expectation is noted before the strobe is taken
    task automatic read_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule

// *** pdic_top_tb_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pdic_top_tb_top
    import pdic_pkg::*;
;
    logic CLOCK_I;
    logic RST_N_I;
    logic [3:0] ADDR_I;
    logic RD_I;
    logic WR_I;
    logic [7:0] WDATA_I;
    logic [7:0] RDATA_O;
    logic [23:0] PIN1_I, PIN1_O, PIN1_OE_N_O, PIN2_I, PIN2_O, PIN2_OE_N_O;
    logic IRQ_O;
    logic [23:0] ext[2];
    logic rd_q = 1'b0;
    int failures = 0;
    int comparisons = 0;

    // Pin level: the design where it drives, else the outside world
    assign PIN1_I = (~PIN1_OE_N_O & PIN1_O) | (PIN1_OE_N_O & ext[0]);
    assign PIN2_I = (~PIN2_OE_N_O & PIN2_O) | (PIN2_OE_N_O & ext[1]);

    pdic_top u_pdic_top (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
        .WR_I(WR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .PIN1_I(PIN1_I), .PIN1_O(PIN1_O),
        .PIN1_OE_N_O(PIN1_OE_N_O), .PIN2_I(PIN2_I), .PIN2_O(PIN2_O),
        .PIN2_OE_N_O(PIN2_OE_N_O), .IRQ_O(IRQ_O));
    pdic_host_model u_pdic_host_model (.clk_i(CLOCK_I), .addr_o(ADDR_I), .rd_o(RD_I),
        .wr_o(WR_I), .wdata_o(WDATA_I));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz
    initial begin
        CLOCK_I = 1'b0;
        forever #10 CLOCK_I = ~CLOCK_I;
    end

    function automatic logic [23:0] oe_of(input logic g);
        return g ? PIN2_OE_N_O : PIN1_OE_N_O;
    endfunction
    function automatic logic [23:0] pin_of(input logic g);
        return g ? PIN2_O : PIN1_O;
    endfunction

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t read data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t request %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLOCK_I);
        #1;
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read data lands one cycle after the strobe; compare with the oldest note
    always @(posedge CLOCK_I) begin
        if (rd_q) begin
            chk_rd(RDATA_O, u_pdic_host_model.exp_q.pop_front());
        end
        rd_q <= RD_I;
    end

    // Watchdog: the tests need well under 10k cycles
    initial begin
        #400000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] dir_word, r, pend;
        logic [23:0] out, eoe, ev;
        logic [3:0] b;
        logic idle;
        void'($urandom(32'hc683));
        ext[0] = 24'($urandom);
        ext[1] = 24'($urandom);
        RST_N_I = 1'b0;
        repeat (20) @(posedge CLOCK_I);
        #1;
        RST_N_I = 1'b1;
        // Reset state, write-only and unmapped places read zero
        for (int g = 0; g < 2; g++) begin
            b = {g[0], 3'b000};
            chk24(oe_of(g[0]), 24'hffffff);
            u_pdic_host_model.read_reg(OFS_IRQ_SETUP1 | b, 8'h00);
            u_pdic_host_model.read_reg(OFS_DIR1 | b, 8'h00);
            u_pdic_host_model.read_reg(4'h6 | b, 8'h00);
        end
        u_pdic_host_model.read_reg(OFS_IRQ_PENDING, 8'h00);
        chk1(IRQ_O, 1'b0);
        $display("test reset done");
        // Every direction word, ignored bits random, output registers rewritten each time
        for (int g = 0; g < 2; g++) begin
            b = {g[0], 3'b000};
            for (int k = 0; k < 16; k++) begin
                r = 8'($urandom);
                dir_word = {r[3:1], k[3], k[2], r[0], k[1], k[0]};
                out = 24'($urandom);
                ext[g] = 24'($urandom);
                u_pdic_host_model.write_reg(OFS_DIR1 | b, dir_word);
                u_pdic_host_model.write_reg(OFS_PORT_A1 | b, out[7:0]);
                u_pdic_host_model.write_reg(OFS_PORT_B1 | b, out[15:8]);
                u_pdic_host_model.write_reg(OFS_PORT_C1 | b, out[23:16]);
                wait_clk(6);
                eoe = {{4{k[2]}}, {4{k[0]}}, {8{k[1]}}, {8{k[3]}}};
                chk24(oe_of(g[0]), eoe);
                chk24(pin_of(g[0]) & ~eoe, out & ~eoe);
                ev = (eoe & ext[g]) | (~eoe & out);
                u_pdic_host_model.read_reg(OFS_PORT_A1 | b, ev[7:0]);
                u_pdic_host_model.read_reg(OFS_PORT_B1 | b, ev[15:8]);
                u_pdic_host_model.read_reg(OFS_PORT_C1 | b, ev[23:16]);
            end
        end
        $display("test direction done");
        // Every trigger mode on both groups, then the same trigger with the enable off
        for (int g = 0; g < 2; g++) begin
            b = {g[0], 3'b000};
            pend = g[0] ? 8'h10 : 8'h01;
            u_pdic_host_model.write_reg(OFS_DIR1 | b, 8'h9b);
            for (int m = 0; m < 4; m++) begin
                idle = ~m[0];
                ext[g][0] = idle;
                wait_clk(6);
                u_pdic_host_model.write_reg(OFS_IRQ_SETUP1 | b, {5'h00, 1'b1, m[1:0]});
                u_pdic_host_model.read_reg(OFS_IRQ_SETUP1 | b, {5'h00, 1'b1, m[1:0]});
                wait_clk(6);
                chk1(IRQ_O, 1'b0);
                ext[g][0] = ~idle;
                wait_clk(6);
                chk1(IRQ_O, 1'b1);
                u_pdic_host_model.read_reg(OFS_IRQ_PENDING, pend);
                if (!m[1]) begin
                    ext[g][0] = idle;
                    wait_clk(6);
                    u_pdic_host_model.read_reg(OFS_IRQ_PENDING, pend);
                end
                u_pdic_host_model.read_reg(OFS_IRQ_PENDING, 8'h00);
                wait_clk(2);
                chk1(IRQ_O, 1'b0);
                u_pdic_host_model.write_reg(OFS_IRQ_SETUP1 | b, {5'h00, 1'b0, m[1:0]});
                ext[g][0] = idle;
                wait_clk(6);
                ext[g][0] = ~idle;
                wait_clk(6);
                chk1(IRQ_O, 1'b0);
                u_pdic_host_model.read_reg(OFS_IRQ_PENDING, 8'h00);
            end
        end
        wait_clk(4);
        $display("test interrupt done");
        test_done();
    end
endmodule
